// ### logic/lafsm_top.sv
// Purpose: Line-termination and network-termination activation machines.
// Assumes: All inputs are synchronous single-cycle or level signals on clk.
// Notes: Both ends are built side by side; only the line-termination end uses the frame strobe.
`timescale 1ns/1ps
module lafsm_top (
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              reset,
    // Framing.
    input  wire logic              frameTick,
    // Line-termination primitives from the network side.
    input  wire logic              activate_request_prim,
    input  wire logic              deactivate_request_prim,
    input  wire logic              remote_loop_request_prim,
    input  wire logic              lt_loop_request_prim,
    input  wire logic              regen_loop_request_prim,
    input  wire logic              customer_side_deactivate_prim,
    input  wire logic              returnNormalReq,
    // Line-termination observations.
    input  wire logic              ltSyncGood,
    input  wire logic              ltRxActBit,
    input  wire logic              signal_or_alignment_loss,
    input  wire logic              remotePowerLoss,
    input  wire logic              customerSideLoss,
    // Line-termination outputs.
    output      logic [1:0]        ltSignal,
    output      logic              deactivation_warning_bit,
    output      logic              ltActivationBit,
    output      logic              line_fault_prim,
    output      logic              customer_side_fault_prim,
    output      logic              ltLoop1Active,
    output      logic              ltLoop1aActive,
    output      logic              lineLastSuperframe,
    output      lafsm_pkg::lafsm_lt_t ltState,
    // Network-termination inputs.
    input  wire logic              ntLineSync,
    input  wire logic              ntRxActBit,
    input  wire logic              partial_activation_bit,
    input  wire logic              customerInfo1,
    input  wire logic              ntSilentEvent,
    input  wire logic              ntRxResetSelect,
    input  wire logic              ntAuxEnter,
    input  wire logic              ntAuxLeave,
    input  wire logic              ntHoldEnter,
    input  wire logic              ntHoldLeave,
    input  wire logic              ntLoop2Cmd,
    input  wire logic              ntBringupFail,
    // Network-termination outputs.
    output      logic              activation_bit,
    output      logic [1:0]        ntSignal,
    output      logic              ntLoop2Active,
    output      lafsm_pkg::lafsm_nt_t ntState
);
    import lafsm_pkg::*;

    lafsm_lt_t              ltState_reg;
    lafsm_nt_t              ntState_reg;
    lafsm_nt_t              ntReturn_reg;
    logic [1:0]             deaCount_reg;
    logic [TIMER_WIDTH-1:0] m5Count_reg;
    logic [TIMER_WIDTH-1:0] m7Count_reg;
    logic                   m5Run_reg;
    logic                   m7Run_reg;
    logic                   m5Expire;
    logic                   m7Expire;
    logic                   timer_start_action;
    logic                   timer_stop_action;
    logic                   m7Start;
    logic                   lineLoss;
    logic                   info1Prev_reg;
    logic                   info1Armed_reg;
    logic                   auxUoa_reg;
    logic                   auxAct_reg;
    logic                   holdAct_reg;
    logic                   ltLoop1_reg;
    logic                   ltLoop1a_reg;
    logic                   loopClear;
    logic                   lineFault_reg;
    logic                   custFault_reg;

    assign lineLoss           = signal_or_alignment_loss | remotePowerLoss;
    assign loopClear          = returnNormalReq | (ltState_reg == LAFSM_LT_RESET);
    assign timer_start_action = (ltState_reg == LAFSM_LT_RESET) & activate_request_prim;
    assign timer_stop_action  = (ltState_reg == LAFSM_LT_SYNC) & ltSyncGood;
    assign m7Start            = lineLoss & (ltState_reg != LAFSM_LT_RESET)
                                & (ltState_reg != LAFSM_LT_RXRESET);
    assign m5Expire = m5Run_reg & frameTick & (m5Count_reg == M5_FRAMES);
    assign m7Expire = m7Run_reg & frameTick & (m7Count_reg == M7_FRAMES);

    // Frame-counted timers.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            m5Run_reg   <= 1'b0;
            m5Count_reg <= '0;
        end else if (timer_start_action) begin
            m5Run_reg   <= 1'b1;
            m5Count_reg <= '0;
        end else if (timer_stop_action | m5Expire) begin
            m5Run_reg   <= 1'b0;
        end else if (m5Run_reg & frameTick) begin
            m5Count_reg <= m5Count_reg + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            m7Run_reg   <= 1'b0;
            m7Count_reg <= '0;
        end else if (m7Start) begin
            m7Run_reg   <= 1'b1;
            m7Count_reg <= '0;
        end else if (m7Expire) begin
            m7Run_reg   <= 1'b0;
        end else if (m7Run_reg & frameTick) begin
            m7Count_reg <= m7Count_reg + 1'b1;
        end
    end

    // Line-termination state machine.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ltState_reg <= LAFSM_LT_RESET;
        end else begin
            unique case (ltState_reg)
                LAFSM_LT_RESET: begin
                    if (activate_request_prim | remote_loop_request_prim) begin
                        ltState_reg <= LAFSM_LT_SYNC;
                    end
                end
                LAFSM_LT_SYNC: begin
                    if (lineLoss) begin
                        ltState_reg <= LAFSM_LT_RXRESET;
                    end else if (m5Expire) begin
                        ltState_reg <= LAFSM_LT_TEARDOWN;
                    end else if (remote_loop_request_prim) begin
                        ltState_reg <= LAFSM_LT_LOOP;
                    end else if (ltRxActBit) begin
                        ltState_reg <= LAFSM_LT_ACTIVE;
                    end
                end
                LAFSM_LT_ACTIVE, LAFSM_LT_LOOP: begin
                    if (lineLoss) begin
                        ltState_reg <= LAFSM_LT_RXRESET;
                    end else if (deactivate_request_prim) begin
                        ltState_reg <= LAFSM_LT_DEA_ALERT;
                    end else if (returnNormalReq & ltState_reg == LAFSM_LT_LOOP) begin
                        ltState_reg <= LAFSM_LT_SYNC;
                    end else if (remote_loop_request_prim) begin
                        ltState_reg <= LAFSM_LT_LOOP;
                    end
                end
                LAFSM_LT_DEA_ALERT: begin
                    if (lineLoss) begin
                        ltState_reg <= LAFSM_LT_RXRESET;
                    end else if (lineLastSuperframe) begin
                        ltState_reg <= LAFSM_LT_TEARDOWN;
                    end
                end
                LAFSM_LT_TEARDOWN: begin
                    if (!ltSyncGood) begin
                        ltState_reg <= LAFSM_LT_RESET;
                    end
                end
                LAFSM_LT_RXRESET: begin
                    if (m7Expire) begin
                        ltState_reg <= LAFSM_LT_RESET;
                    end
                end
                default: ltState_reg <= LAFSM_LT_RESET;
            endcase
        end
    end

    // Warning-bit frame count before the last superframe.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            deaCount_reg <= DEA_CNT_RESET;
        end else if (ltState_reg != LAFSM_LT_DEA_ALERT) begin
            deaCount_reg <= DEA_CNT_RESET;
        end else if (frameTick && deaCount_reg != 2'(DEA_FRAMES)) begin
            deaCount_reg <= deaCount_reg + 2'h1;
        end
    end
    assign lineLastSuperframe = (ltState_reg == LAFSM_LT_DEA_ALERT)
                                & (deaCount_reg == 2'(DEA_FRAMES)) & frameTick;

    // Loopback and fault primitives.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ltLoop1_reg  <= 1'b0;
            ltLoop1a_reg <= 1'b0;
        end else begin
            // A new request wins over a clear in the same cycle.
            ltLoop1_reg  <= lt_loop_request_prim | (ltLoop1_reg & ~loopClear);
            ltLoop1a_reg <= regen_loop_request_prim | (ltLoop1a_reg & ~loopClear);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lineFault_reg <= 1'b0;
            custFault_reg <= 1'b0;
        end else begin
            lineFault_reg <= lineLoss & (ltState_reg != LAFSM_LT_RESET)
                             & (ltState_reg != LAFSM_LT_RXRESET)
                             & (ltState_reg != LAFSM_LT_TEARDOWN);
            custFault_reg <= (customerSideLoss | customer_side_deactivate_prim)
                             & (ltState_reg == LAFSM_LT_ACTIVE);
        end
    end

    // Line-termination outputs; the line stays up on a customer-side deactivate.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ltSignal                 <= SIG_SILENT;
            deactivation_warning_bit <= 1'b1;
            ltActivationBit          <= 1'b0;
        end else begin
            deactivation_warning_bit <= (ltState_reg != LAFSM_LT_DEA_ALERT);
            ltActivationBit <= (ltState_reg == LAFSM_LT_ACTIVE)
                               & ~customer_side_deactivate_prim;
            unique case (ltState_reg)
                LAFSM_LT_SYNC:                      ltSignal <= SIG_SL2;
                LAFSM_LT_ACTIVE, LAFSM_LT_LOOP,
                LAFSM_LT_DEA_ALERT:                 ltSignal <= SIG_SL3;
                default:                            ltSignal <= SIG_SILENT;
            endcase
        end
    end

    // Fresh customer activation detection after a failed bring-up.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            info1Prev_reg  <= 1'b0;
            info1Armed_reg <= 1'b1;
        end else begin
            info1Prev_reg <= customerInfo1;
            if (customerInfo1 & ~info1Prev_reg) begin
                info1Armed_reg <= 1'b1;
            end else if (ntBringupFail) begin
                info1Armed_reg <= 1'b0;
            end
        end
    end

    // Network-termination state machine.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ntState_reg  <= LAFSM_NT_FULLRESET;
            ntReturn_reg <= LAFSM_NT_FULLRESET;
            auxUoa_reg   <= 1'b0;
            auxAct_reg   <= 1'b0;
        end else if (ntSilentEvent) begin
            ntState_reg <= ntRxResetSelect ? LAFSM_NT_RXRESET : LAFSM_NT_FULLRESET;
        end else if (ntBringupFail) begin
            ntState_reg <= LAFSM_NT_FULLRESET;
        end else begin
            unique case (ntState_reg)
                LAFSM_NT_FULLRESET, LAFSM_NT_RXRESET: begin
                    if (customerInfo1 & info1Armed_reg) begin
                        ntState_reg <= LAFSM_NT_AWAKE;
                    end
                end
                LAFSM_NT_AWAKE: begin
                    if (ntLineSync) ntState_reg <= LAFSM_NT_SYNC;
                end
                LAFSM_NT_SYNC, LAFSM_NT_ACTIVE_T, LAFSM_NT_ACTIVE: begin
                    if (ntLoop2Cmd) begin
                        ntState_reg <= LAFSM_NT_LOOP;
                    end else if (ntHoldEnter) begin
                        ntReturn_reg <= ntState_reg;
                        ntState_reg  <= LAFSM_NT_HOLD;
                    end else if (ntAuxEnter) begin
                        ntReturn_reg <= ntState_reg;
                        auxUoa_reg   <= partial_activation_bit;
                        auxAct_reg   <= ntRxActBit;
                        ntState_reg  <= LAFSM_NT_AUX;
                    end else if (ntState_reg == LAFSM_NT_SYNC & ntRxActBit) begin
                        ntState_reg <= LAFSM_NT_ACTIVE;
                    end
                end
                LAFSM_NT_HOLD: begin
                    if (ntHoldLeave) ntState_reg <= ntReturn_reg;
                end
                LAFSM_NT_AUX: begin
                    if (ntAuxLeave) begin
                        if (auxUoa_reg == partial_activation_bit && auxAct_reg == ntRxActBit) begin
                            ntState_reg <= ntReturn_reg;
                        end else begin
                            ntState_reg <= ntRxActBit ? LAFSM_NT_ACTIVE : LAFSM_NT_SYNC;
                        end
                    end
                end
                LAFSM_NT_LOOP: ;
                default: ntState_reg <= LAFSM_NT_FULLRESET;
            endcase
        end
    end

    // Network-termination outputs; the hold state freezes them.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            activation_bit <= 1'b0;
            ntSignal       <= SIG_SILENT;
            holdAct_reg    <= 1'b0;
        end else if (ntState_reg == LAFSM_NT_HOLD) begin
            activation_bit <= holdAct_reg;
        end else begin
            holdAct_reg    <= (ntState_reg == LAFSM_NT_ACTIVE)
                              | (ntState_reg == LAFSM_NT_ACTIVE_T);
            activation_bit <= (ntState_reg == LAFSM_NT_ACTIVE)
                              | (ntState_reg == LAFSM_NT_ACTIVE_T);
            unique case (ntState_reg)
                LAFSM_NT_AWAKE:                      ntSignal <= SIG_SL1;
                LAFSM_NT_SYNC, LAFSM_NT_ACTIVE_T,
                LAFSM_NT_ACTIVE, LAFSM_NT_AUX,
                LAFSM_NT_LOOP:                       ntSignal <= SIG_SL3;
                default:                             ntSignal <= SIG_SILENT;
            endcase
        end
    end

    assign line_fault_prim          = lineFault_reg;
    assign customer_side_fault_prim = custFault_reg;
    assign ltLoop1Active            = ltLoop1_reg;
    assign ltLoop1aActive           = ltLoop1a_reg;
    assign ntLoop2Active            = (ntState_reg == LAFSM_NT_LOOP);
    assign ltState                  = ltState_reg;
    assign ntState                  = ntState_reg;
endmodule : lafsm_top

// ### logic/lafsm_pkg.sv
// Purpose: Constants and state types for the line activation state machines.
// Assumes: One 40 MHz clock; frame strobes arrive from the line framer.
// Notes: Timer lengths are counted in line frames.
package lafsm_pkg;
    localparam int          DEA_FRAMES    = 3;
    localparam int          TIMER_WIDTH   = 12;
    localparam logic [11:0] M5_FRAMES     = 12'hBB8;
    localparam logic [11:0] M7_FRAMES     = 12'h1A0;
    localparam logic [1:0]  SIG_SILENT    = 2'h0;
    localparam logic [1:0]  SIG_SL1       = 2'h1;
    localparam logic [1:0]  SIG_SL2       = 2'h2;
    localparam logic [1:0]  SIG_SL3       = 2'h3;
    localparam logic [1:0]  DEA_CNT_RESET = 2'h0;
    typedef enum logic [2:0] {
        LAFSM_LT_RESET, LAFSM_LT_SYNC, LAFSM_LT_ACTIVE, LAFSM_LT_LOOP,
        LAFSM_LT_DEA_ALERT, LAFSM_LT_TEARDOWN, LAFSM_LT_RXRESET
    } lafsm_lt_t;
    typedef enum logic [3:0] {
        LAFSM_NT_FULLRESET, LAFSM_NT_AWAKE, LAFSM_NT_SYNC, LAFSM_NT_ACTIVE_T,
        LAFSM_NT_ACTIVE, LAFSM_NT_HOLD, LAFSM_NT_AUX, LAFSM_NT_LOOP,
        LAFSM_NT_RXRESET
    } lafsm_nt_t;
endpackage : lafsm_pkg

// ### testbench/lafsm_assertions.sv
// Purpose: Concurrent checks on the line activation machines.
// Assumes: One clock domain with an asynchronous active high reset.
// Notes: Sees only the top module ports.
`timescale 1ns/1ps
module lafsm_assertions
    import lafsm_pkg::*;
(
    // Clock, reset and line-end inputs.
    input wire logic                 clk,
    input wire logic                 reset,
    input wire logic                 frameTick,
    input wire logic                 customer_side_deactivate_prim,
    input wire logic                 returnNormalReq,
    input wire logic                 signal_or_alignment_loss,
    // Line-end outputs.
    input wire logic [1:0]           ltSignal,
    input wire logic                 deactivation_warning_bit,
    input wire logic                 ltActivationBit,
    input wire logic                 line_fault_prim,
    input wire logic                 ltLoop1Active,
    input wire logic                 lineLastSuperframe,
    input wire lafsm_pkg::lafsm_lt_t ltState,
    // Network end.
    input wire logic                 ntLoop2Cmd,
    input wire logic                 activation_bit,
    input wire logic [1:0]           ntSignal,
    input wire logic                 ntLoop2Active,
    input wire lafsm_pkg::lafsm_nt_t ntState
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    logic [2:0] tickCnt_reg;
    // Counts frame strobes seen while the line end is alerting.
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            tickCnt_reg <= 3'h0;
        else if (ltState != LAFSM_LT_DEA_ALERT)
            tickCnt_reg <= 3'h0;
        else if (frameTick && tickCnt_reg != 3'h7)
            tickCnt_reg <= tickCnt_reg + 3'h1;
    end
    chk_warn_low:
        assert property ((ltState == LAFSM_LT_DEA_ALERT) [*2] |-> !deactivation_warning_bit)
            else $error("warning bit high while alerting");
    chk_three_frames:
        assert property (lineLastSuperframe |-> tickCnt_reg >= 3'h3 ##1 ltState == LAFSM_LT_TEARDOWN)
            else $error("last superframe too early or without teardown");
    chk_silent_out:
        assert property ((ltState == LAFSM_LT_TEARDOWN) [*2] |-> ltSignal == SIG_SILENT)
            else $error("line signal not silent in teardown");
    chk_fault_loss:
        assert property (ltState == LAFSM_LT_ACTIVE && signal_or_alignment_loss |=> line_fault_prim)
            else $error("line fault not raised on loss");
    chk_cust_deact:
        assert property ((ltState == LAFSM_LT_ACTIVE && customer_side_deactivate_prim) [*2]
            |-> !ltActivationBit) else $error("activation bit kept on customer deactivate");
    chk_loop_sticky:
        assert property ($fell(ltLoop1Active) |-> $past(returnNormalReq) || $past(returnNormalReq, 2)
            || $past(ltState) == LAFSM_LT_RESET || ltState == LAFSM_LT_RESET)
            else $error("loopback flag dropped without cause");
    chk_hold_freeze:
        assert property ((ntState == LAFSM_NT_HOLD) [*2] |-> $stable(activation_bit)
            && $stable(ntSignal)) else $error("outputs moved in hold state");
    chk_loop2_entry:
        assert property (ntLoop2Cmd && ntState inside {LAFSM_NT_SYNC, LAFSM_NT_ACTIVE}
            |=> ntState == LAFSM_NT_LOOP && ntLoop2Active) else $error("loopback 2 not entered");
    cover property (lineLastSuperframe);
    cover property (ntState == LAFSM_NT_HOLD);
    cover property ($fell(ltLoop1Active));
endmodule : lafsm_assertions
bind lafsm_top lafsm_assertions lafsm_assertions_i (
    .clk, .reset, .frameTick, .customer_side_deactivate_prim, .returnNormalReq,
    .signal_or_alignment_loss, .ltSignal, .deactivation_warning_bit, .ltActivationBit,
    .line_fault_prim, .ltLoop1Active, .lineLastSuperframe, .ltState, .ntLoop2Cmd,
    .activation_bit, .ntSignal, .ntLoop2Active, .ntState
);

// ### testbench/lafsm_line_partner.sv
// Purpose: Remote line transceiver model facing the line termination end.
// Assumes: The frame strobe is made here every FRAME_CLKS clocks.
// Notes: Mode 0 locks promptly, mode 1 slowly, mode 2 never.
`timescale 1ns/1ps
module lafsm_line_partner
    import lafsm_pkg::*;
#(
    parameter int FRAME_CLKS = 6
) (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       reset,
    // Bench control and line.
    input  wire logic [1:0] mode,
    input  wire logic [1:0] ltSignal,
    output      logic       frameTick,
    output      logic       ltSyncGood,
    output      logic       ltRxActBit
);
    logic [3:0] div_reg;
    logic [3:0] seen_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_reg   <= 4'h0;
            frameTick <= 1'b0;
        end else begin
            div_reg   <= (div_reg == 4'(FRAME_CLKS - 1)) ? 4'h0 : div_reg + 4'h1;
            frameTick <= (div_reg == 4'(FRAME_CLKS - 1));
        end
    end
    // Lock after some frames of line signal and lose it at once on silence.
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            seen_reg <= 4'h0;
        else if (ltSignal == SIG_SILENT)
            seen_reg <= 4'h0;
        else if (frameTick && seen_reg != 4'hF)
            seen_reg <= seen_reg + 4'h1;
    end
    assign ltSyncGood = (mode != 2'h2) && (seen_reg >= ((mode == 2'h1) ? 4'h6 : 4'h2));
    // The remote end answers with its activation bit as soon as it has locked.
    assign ltRxActBit = ltSyncGood;
endmodule : lafsm_line_partner

// ### testbench/lafsm_top_tb.sv
// Purpose: Self-checking bench for the line activation machines.
// Assumes: Inputs change on the falling edge of a 40 MHz clock.
// Notes: The partner model makes the frame strobe and the remote line answer.
`timescale 1ns/1ps
module lafsm_top_tb;
    import lafsm_pkg::*;
    localparam int FR = 6;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [1:0] mode = 2'h0;
    logic activate_request_prim = 1'b0, deactivate_request_prim = 1'b0;
    logic remote_loop_request_prim = 1'b0, lt_loop_request_prim = 1'b0;
    logic regen_loop_request_prim = 1'b0, customer_side_deactivate_prim = 1'b0;
    logic returnNormalReq = 1'b0, signal_or_alignment_loss = 1'b0, remotePowerLoss = 1'b0;
    logic customerSideLoss = 1'b0, ntLineSync = 1'b0, ntRxActBit = 1'b0;
    logic partial_activation_bit = 1'b0, customerInfo1 = 1'b0, ntSilentEvent = 1'b0;
    logic ntRxResetSelect = 1'b0, ntAuxEnter = 1'b0, ntAuxLeave = 1'b0, ntHoldEnter = 1'b0;
    logic ntHoldLeave = 1'b0, ntLoop2Cmd = 1'b0, ntBringupFail = 1'b0;
    logic frameTick, ltSyncGood, ltRxActBit, deactivation_warning_bit, ltActivationBit;
    logic line_fault_prim, customer_side_fault_prim, ltLoop1Active, ltLoop1aActive;
    logic lineLastSuperframe, activation_bit, ntLoop2Active;
    logic [1:0] ltSignal, ntSignal;
    lafsm_lt_t ltState;
    lafsm_nt_t ntState;
    int miscompares = 0;
    int checks = 0;
    int n;
    always #12.5 clk = ~clk;
    lafsm_top lafsm_top_i (.*);
    lafsm_line_partner #(.FRAME_CLKS(FR)) lafsm_line_partner_i (
        .clk, .reset, .mode, .ltSignal, .frameTick, .ltSyncGood, .ltRxActBit
    );
    task automatic compare(string what, logic [7:0] exp, logic [7:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask : compare
    task automatic pulse(ref logic sig);
        sig = 1'b1;
        @(negedge clk);
        sig = 1'b0;
    endtask : pulse
    task automatic wait_lt(lafsm_lt_t s, int lim);
        while (ltState !== s && lim > 0) begin
            @(negedge clk);
            lim--;
        end
        compare("ltState", s, ltState);
    endtask : wait_lt
    task automatic wait_nt(lafsm_nt_t s, int lim);
        while (ntState !== s && lim > 0) begin
            @(negedge clk);
            lim--;
        end
        compare("ntState", s, ntState);
    endtask : wait_nt
    task automatic do_reset;
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
    endtask : do_reset
    task automatic bring_lt;
        do_reset();
        pulse(activate_request_prim);
        wait_lt(LAFSM_LT_ACTIVE, 40 * FR);
        repeat (2) @(negedge clk);
    endtask : bring_lt
    task automatic nt_up(logic full);
        customerInfo1 = 1'b0;
        ntLineSync = 1'b0;
        ntRxActBit = 1'b0;
        do_reset();
        customerInfo1 = 1'b1;
        wait_nt(LAFSM_NT_AWAKE, 20);
        ntLineSync = full;
        ntRxActBit = full;
        if (full)
            wait_nt(LAFSM_NT_ACTIVE, 40);
    endtask : nt_up
    task automatic wrap_up;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
    initial begin
        @(negedge clk);
        do_reset();
        compare("warnBit", 8'h01, deactivation_warning_bit);
        compare("ntState", LAFSM_NT_FULLRESET, ntState);
        repeat (4 * FR) @(negedge clk);
        compare("ltState", LAFSM_LT_RESET, ltState);
        compare("ltSignal", SIG_SILENT, ltSignal);
        bring_lt();
        compare("ltActBit", 8'h01, ltActivationBit);
        pulse(lt_loop_request_prim);
        pulse(regen_loop_request_prim);
        @(negedge clk);
        compare("loop1", 8'h01, ltLoop1Active);
        compare("loop1a", 8'h01, ltLoop1aActive);
        pulse(returnNormalReq);
        repeat (2) @(negedge clk);
        compare("loop1", 8'h00, ltLoop1Active + ltLoop1aActive);
        customer_side_deactivate_prim = 1'b1;
        repeat (3) @(negedge clk);
        compare("ltState", LAFSM_LT_ACTIVE, ltState);
        compare("ltActBit", 8'h00, ltActivationBit);
        compare("custFault", 8'h01, customer_side_fault_prim);
        customer_side_deactivate_prim = 1'b0;
        customerSideLoss = 1'b1;
        repeat (3) @(negedge clk);
        compare("custFault", 8'h01, customer_side_fault_prim);
        customerSideLoss = 1'b0;
        pulse(remote_loop_request_prim);
        compare("ltState", LAFSM_LT_LOOP, ltState);
        bring_lt();
        pulse(deactivate_request_prim);
        compare("ltState", LAFSM_LT_DEA_ALERT, ltState);
        n = 0;
        for (int i = 0; i < 8 * FR && !lineLastSuperframe; i++) begin
            n += frameTick;
            @(negedge clk);
        end
        compare("warnBit", 8'h00, deactivation_warning_bit);
        compare("framesWarned", 8'h01, n >= DEA_FRAMES);
        repeat (2) @(negedge clk);
        compare("ltState", LAFSM_LT_TEARDOWN, ltState);
        compare("ltSignal", SIG_SILENT, ltSignal);
        mode = 2'h1;
        bring_lt();
        signal_or_alignment_loss = 1'b1;
        @(negedge clk);
        compare("lineFault", 8'h01, line_fault_prim);
        wait_lt(LAFSM_LT_RXRESET, 2);
        signal_or_alignment_loss = 1'b0;
        repeat ((M7_FRAMES - 2) * FR) @(negedge clk);
        compare("ltState", LAFSM_LT_RXRESET, ltState);
        wait_lt(LAFSM_LT_RESET, 6 * FR);
        mode = 2'h0;
        bring_lt();
        remotePowerLoss = 1'b1;
        @(negedge clk);
        compare("lineFault", 8'h01, line_fault_prim);
        remotePowerLoss = 1'b0;
        mode = 2'h2;
        do_reset();
        pulse(activate_request_prim);
        repeat ((M5_FRAMES - 1) * FR) @(negedge clk);
        compare("ltState", LAFSM_LT_SYNC, ltState);
        wait_lt(LAFSM_LT_TEARDOWN, 4 * FR);
        mode = 2'h0;
        for (int s = 0; s < 2; s++) begin
            nt_up(1'b1);
            ntRxResetSelect = s[0];
            pulse(ntSilentEvent);
            compare("ntState", s ? LAFSM_NT_RXRESET : LAFSM_NT_FULLRESET, ntState);
        end
        nt_up(1'b1);
        pulse(ntLoop2Cmd);
        compare("ntState", LAFSM_NT_LOOP, ntState);
        compare("loop2", 8'h01, ntLoop2Active);
        nt_up(1'b1);
        pulse(ntHoldEnter);
        repeat (3) @(negedge clk);
        compare("ntState", LAFSM_NT_HOLD, ntState);
        compare("actBit", 8'h01, activation_bit);
        compare("ntSignal", SIG_SL3, ntSignal);
        pulse(ntHoldLeave);
        nt_up(1'b1);
        pulse(ntAuxEnter);
        compare("ntState", LAFSM_NT_AUX, ntState);
        pulse(ntAuxLeave);
        compare("ntState", LAFSM_NT_ACTIVE, ntState);
        pulse(ntAuxEnter);
        ntRxActBit = 1'b0;
        pulse(ntAuxLeave);
        compare("ntState", LAFSM_NT_SYNC, ntState);
        nt_up(1'b0);
        pulse(ntBringupFail);
        repeat (4) @(negedge clk);
        compare("ntState", LAFSM_NT_FULLRESET, ntState);
        customerInfo1 = 1'b0;
        repeat (2) @(negedge clk);
        customerInfo1 = 1'b1;
        wait_nt(LAFSM_NT_AWAKE, 20);
        wrap_up();
    end
endmodule : lafsm_top_tb
